/* File: ucc_assertions.sv */
// Link protocol checks between the host end and the device end.
// Assumes it sits beside the link and sees its signals unchanged.
`timescale 1ns/10ps
module ucc_assertions
   import ucc_pkg::*;
(
   // Clock and reset
   input logic        clk_i,
   input logic        rst_i,
   // Link signals
   input logic        req_valid,
   input logic [7:0]  req_node,
   input logic [7:0]  req_addr,
   input logic [31:0] req_wdata,
   input logic        rsp_valid,
   input logic [7:0]  rsp_node,
   input logic [31:0] rsp_data
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_rd;
      req_valid && !req_addr[WR_BIT];
   endsequence
   sequence s_wr;
      req_valid && req_addr[WR_BIT];
   endsequence
   sequence s_cfg_rd;
      req_valid && req_addr == {1'b0, REG_CFG};
   endsequence
   sequence s_set_node;
      req_valid && req_addr == {1'b1, REG_NODE} && req_node == NODE_DFLT;
   endsequence
   sequence s_release;
      req_valid && req_addr == {1'b1, REG_OUTPUT} && req_wdata == 32'h100;
   endsequence

   AST_RSP_NODE:
      assert property (rsp_valid |-> rsp_node == NODE_MASTER)
      else $error("reply not sent to master node");
   AST_RSP_IDLE:
      assert property (!rsp_valid |-> rsp_node == 8'h00 && rsp_data == 32'h0)
      else $error("reply lines not idle");
   AST_RSP_CAUSE:
      assert property (rsp_valid |-> $past(req_valid))
      else $error("reply without request");
   AST_WR_SILENT:
      assert property (s_wr |=> !rsp_valid)
      else $error("write was answered");
   AST_RSP_PULSE:
      assert property (rsp_valid |=> !rsp_valid)
      else $error("reply longer than one cycle");
   AST_REQ_NODE:
      assert property (req_valid |-> req_node != NODE_MASTER)
      else $error("request to master node");
   AST_ASSIGN_SEQ:
      assert property (s_set_node |=> s_release)
      else $error("chain pin not released after address set");
   AST_READ_WAIT:
      assert property (s_rd |=> !req_valid)
      else $error("request while read pending");
   AST_CFG_WIDTH:
      assert property (s_cfg_rd |=> rsp_data[31:8] == 24'h0)
      else $error("config reply upper bits set");
endmodule

/* File: ucc_device.sv */
// Device end: node address, chain pin and global configuration flags.
// Assumes a host on ucc_link_if on the same clock; chain pins are async.
// Function
// (R1) Strap levels give two devices different addresses
// (R2) Chaining addresses up to 255 devices
// (R3) Reset address: 0 if chain low, else 1
// (R4) Host drives chain pin low after addressing
// (R5) Host addresses devices one by one in order
// (R6) Low chain output enables next bus switch
// (R7) All registers reset to zero
// (R8) Writes add 0x80; top bit marks write
// (R9) Single mode: driver two copies driver one
// (R10) Host sets single mode before drivers run
// (R11) Config bit 1 gates port one steps
// (R12) Config bit 2 gates port two steps
// (R13) Config bit 7 routes test signal to probe
// (R14) Effective address is field plus chain input
// (R15) Address field resets 0, accepts 0 to 253
// (R16) Address 0xff never adopted by a slave
// (R17) Config bits 3 to 6 have no function
`timescale 1ns/10ps
module ucc_device
   import ucc_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Link to the host
   ucc_link_if.dev   link,
   // Chain pins
   input  wire logic chain_select_input_i,
   input  wire logic general_io_pin_zero_i,
   output logic      general_io_pin_zero_o,
   output logic      general_io_pin_zero_oe_o,
   // Step and direction inputs
   input  wire logic step_pulse_one_i,
   input  wire logic direction_one_i,
   input  wire logic step_pulse_two_i,
   input  wire logic direction_two_i,
   // Driver side outputs
   output logic      drv1_step_o,
   output logic      drv1_dir_o,
   output logic      drv2_step_o,
   output logic      drv2_dir_o,
   output logic      probe_route_o,
   output logic      single_mode_o,
   output logic [7:0] node_address_o
);

   typedef struct packed {
      logic [7:0]  cfg;
      logic [7:0]  node;
      logic        pin_out;
      logic        pin_dir;
      logic [2:0]  chn_s;
      logic        chn;
      logic [2:0]  io_s;
      logic        io_in;
      logic        rsp_valid;
      logic [31:0] rsp_data;
      logic        d1_step;
      logic        d1_dir;
      logic        d2_step;
      logic        d2_dir;
   } ucc_dev_st_t;

   ucc_dev_st_t st_r;
   ucc_dev_st_t st_nxt;
   logic [7:0]  eff_node;
   logic        hit;
   logic        is_wr;
   logic [6:0]  reg_idx;

   // Three stage sync; a change counts once stages two and three agree
   function automatic logic sync_level(input logic [2:0] s,
                                       input logic       cur);
      sync_level = (s[1] == s[2]) ? s[2] : cur;
   endfunction

   function automatic logic [31:0] rd_mux(input logic [6:0]  a,
                                          input ucc_dev_st_t s);
      rd_mux = DATA_RST;
      case (a)
         REG_CFG: begin
            rd_mux[7:0] = s.cfg;
         end
         REG_INPUT: begin
            rd_mux[IN_PIN]   = s.io_in;
            rd_mux[IN_CHAIN] = s.chn;
         end
         default: begin
            rd_mux = DATA_RST;
         end
      endcase
   endfunction

   // Field tops out at 253 so the sum never reaches 0xff
   assign eff_node = st_r.node + {7'h00, st_r.chn};      // (R14) (R16)
   assign is_wr    = link.req_addr[WR_BIT];               // (R8)
   assign reg_idx  = link.req_addr[6:0];
   assign hit      = link.req_valid && (link.req_node == eff_node);

   always_comb begin
      st_nxt = st_r;
      st_nxt.chn_s = {st_r.chn_s[1:0], chain_select_input_i};
      st_nxt.chn   = sync_level(st_r.chn_s, st_r.chn);   // (R1) (R3)
      st_nxt.io_s  = {st_r.io_s[1:0], general_io_pin_zero_i};
      st_nxt.io_in = sync_level(st_r.io_s, st_r.io_in);
      st_nxt.rsp_valid = 1'b0;
      st_nxt.rsp_data  = DATA_RST;
      if (hit && is_wr) begin                             // (R8)
         case (reg_idx)
            REG_CFG: begin
               st_nxt.cfg = link.req_wdata[7:0];          // (R17)
            end
            REG_NODE: begin
               if (link.req_wdata[7:0] <= NODE_MAX) begin
                  st_nxt.node = link.req_wdata[7:0];      // (R15) (R16)
               end
            end
            REG_OUTPUT: begin
               st_nxt.pin_out = link.req_wdata[OUT_PIN];  // (R4) (R6)
               st_nxt.pin_dir = link.req_wdata[OUT_DIR0];
            end
            default: begin
               st_nxt.cfg = st_r.cfg;
            end
         endcase
      end else if (hit) begin
         st_nxt.rsp_valid = 1'b1;
         st_nxt.rsp_data  = rd_mux(reg_idx, st_r);
      end
      // Port gating and single motor mirroring
      st_nxt.d1_step = step_pulse_one_i & st_r.cfg[GC_PORT1];  // (R11)
      st_nxt.d1_dir  = direction_one_i;
      if (st_r.cfg[GC_SINGLE]) begin                      // (R9)
         st_nxt.d2_step = st_nxt.d1_step;
         st_nxt.d2_dir  = st_nxt.d1_dir;
      end else begin
         st_nxt.d2_step = step_pulse_two_i & st_r.cfg[GC_PORT2]; // (R12)
         st_nxt.d2_dir  = direction_two_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin                                    // (R7)
         st_r           <= '0;
         st_r.cfg       <= CFG_RST;
         st_r.node      <= NODE_RST;
         st_r.rsp_data  <= DATA_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Link answer
   assign link.rsp_valid = st_r.rsp_valid;
   assign link.rsp_node  = st_r.rsp_valid ? NODE_MASTER : NODE_DFLT; // (R16)
   assign link.rsp_data  = st_r.rsp_data;

   // Chain pin: released until software makes it an output
   assign general_io_pin_zero_o    = st_r.pin_out;        // (R2) (R4)
   assign general_io_pin_zero_oe_o = st_r.pin_dir;        // (R6)

   assign drv1_step_o    = st_r.d1_step;
   assign drv1_dir_o     = st_r.d1_dir;
   assign drv2_step_o    = st_r.d2_step;
   assign drv2_dir_o     = st_r.d2_dir;
   assign probe_route_o  = st_r.cfg[GC_TEST];             // (R13)
   assign single_mode_o  = st_r.cfg[GC_SINGLE];
   assign node_address_o = eff_node;

endmodule

/* File: ucc_host.sv */
// Host end: Wishbone command registers drive the register access link.
// Assumes a classic Wishbone master and one clock shared with devices.
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module ucc_host
   import ucc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Link to the devices
   ucc_link_if.host         link
);

   typedef enum logic [2:0] {
      H_IDLE  = 3'b001,
      H_WAIT  = 3'b010,
      H_CHAIN = 3'b100
   } ucc_hstate_t;

   typedef struct packed {
      ucc_hstate_t fsm;
      logic [7:0]  node;
      logic [6:0]  regi;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic        done;
      logic        tout;
      logic [7:0]  cnt;
      logic        ack;
      logic [31:0] dat;
      logic        rq_v;
      logic [7:0]  rq_node;
      logic [7:0]  rq_addr;
      logic [31:0] rq_data;
   } ucc_host_st_t;

   ucc_host_st_t st_r;
   ucc_host_st_t st_nxt;
   logic         wr_cmt;
   logic         busy;
   logic [31:0]  stat;

   assign busy   = (st_r.fsm != H_IDLE);
   assign wr_cmt = cyc_i && stb_i && we_i && st_r.ack;

   always_comb begin
      stat         = DATA_RST;
      stat[S_BUSY] = busy;
      stat[S_DONE] = st_r.done;
      stat[S_TOUT] = st_r.tout;
   end

   always_comb begin
      st_nxt      = st_r;
      st_nxt.rq_v = 1'b0;
      st_nxt.ack  = cyc_i && stb_i && !st_r.ack;
      if (cyc_i && stb_i && !st_r.ack) begin
         case (adr_i)
            H_NODE:  st_nxt.dat = {24'h0, st_r.node};
            H_REG:   st_nxt.dat = {25'h0, st_r.regi};
            H_WDATA: st_nxt.dat = st_r.wdata;
            H_RDATA: st_nxt.dat = st_r.rdata;
            H_STAT:  st_nxt.dat = stat;
            default: st_nxt.dat = DATA_RST;
         endcase
      end
      // Register writes take effect at the acknowledged edge
      if (wr_cmt && sel_i[0]) begin
         case (adr_i)
            H_NODE: st_nxt.node = dat_i[7:0];
            H_REG:  st_nxt.regi = dat_i[6:0];
            H_STAT: begin
               if (dat_i[S_DONE]) st_nxt.done = 1'b0;
               if (dat_i[S_TOUT]) st_nxt.tout = 1'b0;
            end
            default: st_nxt.cnt = st_r.cnt;
         endcase
      end
      if (wr_cmt && adr_i == H_WDATA) begin
         for (int b = 0; b < 4; b++) begin
            if (sel_i[b]) st_nxt.wdata[8*b +: 8] = dat_i[8*b +: 8];
         end
      end
      // Command engine; set of a sticky flag wins over its clear
      case (st_r.fsm)
         H_IDLE: begin
            if (wr_cmt && sel_i[0] && adr_i == H_CTRL && dat_i[C_GO]) begin
               st_nxt.rq_v = 1'b1;
               st_nxt.cnt  = 8'h00;
               if (dat_i[C_ASSIGN]) begin
                  // Fresh device answers at the default node
                  st_nxt.rq_node = NODE_DFLT;              // (R5)
                  st_nxt.rq_addr = {1'b0, REG_NODE} | WR_FLAG; // (R8)
                  st_nxt.rq_data = {24'h0, st_r.node};
                  st_nxt.fsm     = H_CHAIN;
               end else begin
                  st_nxt.rq_node = st_r.node;
                  st_nxt.rq_data = st_r.wdata;
                  if (dat_i[C_WRITE]) begin
                     st_nxt.rq_addr = {1'b0, st_r.regi} | WR_FLAG; // (R8)
                     st_nxt.done    = 1'b1;
                  end else begin
                     st_nxt.rq_addr = {1'b0, st_r.regi};
                     st_nxt.fsm     = H_WAIT;
                  end
               end
            end
         end
         H_WAIT: begin
            st_nxt.cnt = st_r.cnt + 8'h01;
            if (link.rsp_valid && link.rsp_node == NODE_MASTER) begin
               st_nxt.rdata = link.rsp_data;
               st_nxt.done  = 1'b1;
               st_nxt.fsm   = H_IDLE;
            end else if (st_r.cnt == REPLY_WAIT_CYC) begin
               st_nxt.tout = 1'b1;
               st_nxt.fsm  = H_IDLE;
            end
         end
         H_CHAIN: begin
            // Release the next device: chain pin output, driven low
            st_nxt.rq_v    = 1'b1;                          // (R4) (R6)
            st_nxt.rq_node = st_r.node;
            st_nxt.rq_addr = {1'b0, REG_OUTPUT} | WR_FLAG;
            st_nxt.rq_data = DATA_RST;
            st_nxt.rq_data[OUT_DIR0] = 1'b1;
            st_nxt.done    = 1'b1;
            st_nxt.fsm     = H_IDLE;
         end
         default: begin
            st_nxt.fsm = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r     <= '0;
         st_r.fsm <= H_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dat_o          = st_r.dat;
   assign ack_o          = st_r.ack;
   assign link.req_valid = st_r.rq_v;
   assign link.req_node  = st_r.rq_node;
   assign link.req_addr  = st_r.rq_addr;
   assign link.req_wdata = st_r.rq_data;

endmodule

/* File: ucc_link_if.sv */
// Register access link between the host end and one device end.
// Assumes both ends share clk_i; a request is a one-cycle pulse.
`timescale 1ns/10ps
interface ucc_link_if;
   logic        req_valid;
   logic [7:0]  req_node;
   logic [7:0]  req_addr;
   logic [31:0] req_wdata;
   logic        rsp_valid;
   logic [7:0]  rsp_node;
   logic [31:0] rsp_data;

   modport host (
      output req_valid,
      output req_node,
      output req_addr,
      output req_wdata,
      input  rsp_valid,
      input  rsp_node,
      input  rsp_data
   );

   modport dev (
      input  req_valid,
      input  req_node,
      input  req_addr,
      input  req_wdata,
      output rsp_valid,
      output rsp_node,
      output rsp_data
   );
endinterface

/* File: ucc_pkg.sv */
// Shared constants for the node address chain configuration block.
// Assumes both ends are built on one 200 MHz clock.
package ucc_pkg;
   // Device register indices and the write flag added on writes
   localparam logic [6:0] REG_CFG     = 7'h00;
   localparam logic [6:0] REG_NODE    = 7'h03;
   localparam logic [6:0] REG_INPUT   = 7'h04;
   localparam logic [6:0] REG_OUTPUT  = 7'h05;
   localparam logic [7:0] WR_FLAG     = 8'h80;
   localparam int         WR_BIT      = 7;
   // Node addresses
   localparam logic [7:0] NODE_MAX    = 8'hfd;
   localparam logic [7:0] NODE_MASTER = 8'hff;
   localparam logic [7:0] NODE_DFLT   = 8'h00;
   // Global configuration bit positions
   localparam int GC_SINGLE = 0;
   localparam int GC_PORT1  = 1;
   localparam int GC_PORT2  = 2;
   localparam int GC_TEST   = 7;
   // Input and output register bit positions
   localparam int IN_PIN    = 0;
   localparam int IN_CHAIN  = 6;
   localparam int OUT_PIN   = 0;
   localparam int OUT_DIR0  = 8;
   // Reset values
   localparam logic [7:0]  CFG_RST   = 8'h00;
   localparam logic [7:0]  NODE_RST  = 8'h00;
   localparam logic [31:0] DATA_RST  = 32'h0000_0000;
   // Host register byte offsets on the Wishbone bus
   localparam logic [7:0] H_CTRL  = 8'h00;
   localparam logic [7:0] H_NODE  = 8'h04;
   localparam logic [7:0] H_REG   = 8'h08;
   localparam logic [7:0] H_WDATA = 8'h0c;
   localparam logic [7:0] H_RDATA = 8'h10;
   localparam logic [7:0] H_STAT  = 8'h14;
   // Host control and status bit positions
   localparam int C_GO     = 0;
   localparam int C_WRITE  = 1;
   localparam int C_ASSIGN = 2;
   localparam int S_BUSY   = 0;
   localparam int S_DONE   = 1;
   localparam int S_TOUT   = 2;
   // Cycles the host waits for a read reply
   localparam logic [7:0] REPLY_WAIT_CYC = 8'h40;
endpackage

/* File: ucc_tb_top.sv */
// Testbench: host and device joined by the link, driven over Wishbone.
// Assumes one 200 MHz clock and a pulled-up chain pin wire.
`timescale 1ns/10ps
`define CHK(g, e) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("[ERR] %0t got %h exp %h", $time, g, e); \
   end \
end
module ucc_tb_top
   import ucc_pkg::*;
;
   logic        clk_i;
   logic        rst_i;
   logic        cyc, stb, we, ack;
   logic [7:0]  adr, node;
   logic [31:0] wdat, rdat, st, q;
   logic        chain, stp_a, dir_a, stp_b, dir_b;
   logic [3:0]  sel;
   logic        pin_o, pin_oe, d1s, d1d, d2s, d2d, probe, single;
   int          fail_count;
   int          comparisons;
   // Pull-up on the chain pin while the device releases it
   wire         pin = pin_oe ? pin_o : 1'b1;

   ucc_link_if link ();
   ucc_host u_ucc_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .link(link));
   ucc_device u_ucc_device (.clk_i(clk_i), .rst_i(rst_i), .link(link),
      .chain_select_input_i(chain), .general_io_pin_zero_i(pin),
      .general_io_pin_zero_o(pin_o), .general_io_pin_zero_oe_o(pin_oe),
      .step_pulse_one_i(stp_a), .direction_one_i(dir_a),
      .step_pulse_two_i(stp_b), .direction_two_i(dir_b),
      .drv1_step_o(d1s), .drv1_dir_o(d1d), .drv2_step_o(d2s),
      .drv2_dir_o(d2d), .probe_route_o(probe), .single_mode_o(single),
      .node_address_o(node));
   ucc_assertions u_ucc_assertions (.clk_i(clk_i), .rst_i(rst_i),
      .req_valid(link.req_valid), .req_node(link.req_node),
      .req_addr(link.req_addr), .req_wdata(link.req_wdata),
      .rsp_valid(link.rsp_valid), .rsp_node(link.rsp_node),
      .rsp_data(link.rsp_data));

   always #2.5 clk_i = ~clk_i;

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      // Waits for ack as long as it takes; the watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      `CHK(ack, 1'b1)
   endtask

   // One link command through the host registers, then status and data
   task automatic dcmd(input logic [7:0] n, input logic [6:0] i,
                       input logic [31:0] d, input logic [2:0] c);
      logic [31:0] x;
      wb(1'b1, H_NODE, {24'h0, n}, x);
      wb(1'b1, H_REG, {25'h0, i}, x);
      wb(1'b1, H_WDATA, d, x);
      wb(1'b1, H_CTRL, {29'h0, c}, x);
      repeat (60) begin
         wb(1'b0, H_STAT, 32'h0, st);
         if (st[S_DONE] || st[S_TOUT])
            break;
      end
      wb(1'b0, H_RDATA, 32'h0, q);
      wb(1'b1, H_STAT, 32'h6, x);
   endtask

   task automatic t_reset();
      `CHK(node, NODE_DFLT)
      `CHK({pin_oe, single, probe}, 3'h0)
      wb(1'b1, 8'h20, 32'h5a, q);
      wb(1'b0, 8'h20, 32'h0, q);
      `CHK(q, 32'h0)
      chain <= 1'b1;
      repeat (8) @(posedge clk_i);
      `CHK(node, 8'h01)
      dcmd(8'h01, REG_CFG, 32'h0, 3'h1);
      `CHK(st[S_DONE], 1'b1)
      `CHK(q, 32'h0)
      dcmd(8'h00, REG_CFG, 32'h0, 3'h1);
      `CHK(st[S_TOUT], 1'b1)
      chain <= 1'b0;
      repeat (8) @(posedge clk_i);
      $display("test reset done");
   endtask

   task automatic t_config();
      logic [7:0] v [8] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h03, 8'h05,
                           8'h80, 8'h78};
      stp_a <= 1'b1;
      dir_a <= 1'b1;
      stp_b <= 1'b1;
      dir_b <= 1'b0;
      foreach (v[k]) begin
         // Mode flag settles with both ports gated off first
         dcmd(8'h00, REG_CFG, {31'h0, v[k][GC_SINGLE]}, 3'h3);
         dcmd(8'h00, REG_CFG, {24'h0, v[k]}, 3'h3);
         dcmd(8'h00, REG_CFG, 32'h0, 3'h1);
         `CHK(q, {24'h0, v[k]})
         `CHK(d1s, v[k][GC_PORT1])
         `CHK(d1d, 1'b1)
         `CHK(d2s, v[k][GC_SINGLE] ? v[k][GC_PORT1] : v[k][GC_PORT2])
         `CHK(d2d, v[k][GC_SINGLE])
         `CHK(single, v[k][GC_SINGLE])
         `CHK(probe, v[k][GC_TEST])
      end
      dcmd(8'h00, REG_CFG, 32'h0, 3'h3);
      $display("test config done");
   endtask

   task automatic t_assign();
      dcmd(8'h05, 7'h00, 32'h0, 3'h5);
      `CHK(node, 8'h05)
      `CHK({pin_oe, pin_o, pin}, 3'h4)
      dcmd(8'h05, REG_INPUT, 32'h0, 3'h1);
      `CHK({q[IN_CHAIN], q[IN_PIN]}, 2'h0)
      dcmd(8'h05, REG_NODE, 32'hfe, 3'h3);
      `CHK(node, 8'h05)
      dcmd(8'h05, REG_NODE, {24'h0, NODE_MAX}, 3'h3);
      `CHK(node, NODE_MAX)
      chain <= 1'b1;
      repeat (8) @(posedge clk_i);
      `CHK(node, 8'hfe)
      dcmd(8'hfe, REG_OUTPUT, 32'h1, 3'h3);
      dcmd(8'hfe, REG_INPUT, 32'h0, 3'h1);
      `CHK({q[IN_CHAIN], q[IN_PIN]}, 2'h3)
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      `CHK({node, pin_oe}, 9'h002)
      chain <= 1'b0;
      repeat (8) @(posedge clk_i);
      $display("test assign done");
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      {cyc, stb, we, adr, sel, wdat} = '0;
      {chain, stp_a, dir_a, stp_b, dir_b} = '0;
      fail_count = 0;
      comparisons = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      t_reset();
      t_config();
      t_assign();
      tally_and_finish();
   end

   // Cuts a hang short well after the expected run length
   initial begin
      repeat (30000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end
endmodule
